/* logic/rbmd_cfg.svh */
// constants for the block mode decoder: field positions, widths, latency
// assumes inclusion by bare name from package and design files
`ifndef RBMD_CFG_SVH
`define RBMD_CFG_SVH
`define RBMD_WORD_W 64
`define RBMD_DIFF_BIT 33
`define RBMD_ORIENT_BIT 32
`define RBMD_RED_HI 63
`define RBMD_GREEN_HI 55
`define RBMD_BLUE_HI 47
`define RBMD_SEL1_LO 37
`define RBMD_SEL2_LO 34
`define RBMD_IDX_MSB_LO 16
`define RBMD_IDX_LSB_LO 0
`define RBMD_SUM_MAX 31
`define RBMD_FIFO_DEPTH 16
`define RBMD_LATENCY 2
`endif

/* logic/rbmd_pkg.sv */
// types for the block mode decoder
// assumes rbmd_cfg.svh on the include path
`include "rbmd_cfg.svh"
package rbmd_pkg;
    typedef enum logic [2:0]
    {
        RBMD_INDIVIDUAL = 3'h0,
        RBMD_DIFFERENTIAL = 3'h1,
        RBMD_T_MODE = 3'h2,
        RBMD_H_MODE = 3'h3,
        RBMD_PLANAR = 3'h4
    } rbmd_mode_t;
    typedef struct packed
    {
        logic [63:0] word;
        logic [1:0] col;
        logic [1:0] row;
    } rbmd_req_t;
    typedef struct packed
    {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
        rbmd_mode_t mode;
    } rbmd_resp_t;
endpackage

/* logic/rbmd_decoder.sv */
// block mode decoder for 64-bit compressed 4x4 texel blocks, with output fifo
// assumes one 25 MHz clock, synchronous active-high reset, requester on same clock
`timescale 1ns/1ps
`include "rbmd_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module rbmd_fifo #(
    parameter int WIDTH = 27,
    parameter int DEPTH = `RBMD_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed
    {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
    } rbmd_fifo_state_t;
    rbmd_fifo_state_t st_q;
    rbmd_fifo_state_t st_d;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic push;
    logic pop;
    assign in_ready = (st_q.count != (AW+1)'(DEPTH));
    assign out_valid = (st_q.count != '0);
    assign out_data = mem_q[st_q.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_comb
    begin
        st_d = st_q;
        if (push)
        begin
            st_d.wr = st_q.wr + AW'(1);
        end
        if (pop)
        begin
            st_d.rd = st_q.rd + AW'(1);
        end
        if (push && !pop)
        begin
            st_d.count = st_q.count + (AW+1)'(1);
        end
        else if (pop && !push)
        begin
            st_d.count = st_q.count - (AW+1)'(1);
        end
    end
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_q[st_q.wr] <= in_data;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RL1 - each 64-bit word encodes one 4x4 block, columns a-d, e-h, i-l, m-p
// RL2 - differential flag 0 selects individual mode, sums ignored
// RL3 - colour fields unsigned 0..31, deltas two's complement -4..+3
// RL4 - flag 1 and red sum out of 0..31 selects T mode
// RL5 - red sum fine, green sum out of range selects H mode
// RL6 - red and green fine, blue sum out of range selects planar
// RL7 - differential mode only when flag 1 and all sums in range
// RL8 - bit 32 is the split orientation bit in individual and differential
// RL9 - orientation 0: left two columns subblock 1, right two subblock 2
// RL10 - orientation 1: top two rows subblock 1, bottom two subblock 2
// RL11 - individual subblock 1 nibbles at 63-60, 55-52, 47-44
// RL12 - individual subblock 2 nibbles at 59-56, 51-48, 43-40
// RL13 - nibbles widen to bytes by repeating the nibble
// RL14 - individual upper half: nibbles, selectors, zero flag, orientation
// RL15 - differential field layout: 5-bit colours with 3-bit deltas, selectors
// RL16 - 5-bit colour widens by appending its top three bits
// RL17 - differential subblock 2 is colour plus delta, widened alike
// RL18 - pixel index msb from bits 31-16, lsb from 15-0, a lowest
// RL19 - T mode upper half holds split colour and distance fields
// RL20 - planar origin red is bits 62-57
// RL21 - selector picks one of eight small/large magnitude pairs
// RL22 - index 11 -large, 10 -small, 00 +small, 01 +large
// RL23 - modifier added to all channels, clamped to 0..255
// RL24 - request word plus col/row with valid; answer colour and mode later
module rbmd_decoder #(
    parameter int FIFO_DEPTH = `RBMD_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // request from texture fetch
    input wire logic req_valid,
    output logic req_ready,
    input wire rbmd_pkg::rbmd_req_t req,
    // answer to sampler
    output logic resp_valid,
    input wire logic resp_ready,
    output rbmd_pkg::rbmd_resp_t resp
);
    import rbmd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed
    {
        logic ready;
        logic s1_valid;
        rbmd_mode_t s1_mode;
        logic [23:0] s1_base;
        logic [7:0] s1_mod;
        logic s1_neg;
        logic [3:0] s1_pix;
        logic s2_valid;
        rbmd_resp_t s2_resp;
        logic out_valid;
        rbmd_resp_t out_resp;
    } rbmd_state_t;
    rbmd_state_t st_q;
    rbmd_state_t st_d;

    logic fifo_in_ready;
    logic fifo_out_valid;
    rbmd_resp_t fifo_out_data;
    logic advance;

    // stages move only on a registered ready, which is low while the output register holds an answer
    assign advance = st_q.ready;
    assign req_ready = st_q.ready; // see RL24

    function automatic logic [7:0] nibble_widen(input logic [3:0] n);
        nibble_widen = {n, n}; // see RL13
    endfunction

    function automatic logic [7:0] quint_widen(input logic [4:0] q);
        quint_widen = {q, q[4:2]}; // see RL16
    endfunction

    function automatic logic [7:0] small_mag(input logic [2:0] s);
        case (s) // see RL21
            3'h0: small_mag = 8'h02;
            3'h1: small_mag = 8'h05;
            3'h2: small_mag = 8'h09;
            3'h3: small_mag = 8'h0d;
            3'h4: small_mag = 8'h12;
            3'h5: small_mag = 8'h18;
            3'h6: small_mag = 8'h21;
            default: small_mag = 8'h2f;
        endcase
    endfunction

    function automatic logic [7:0] large_mag(input logic [2:0] s);
        case (s) // see RL21
            3'h0: large_mag = 8'h08;
            3'h1: large_mag = 8'h11;
            3'h2: large_mag = 8'h1d;
            3'h3: large_mag = 8'h2a;
            3'h4: large_mag = 8'h3c;
            3'h5: large_mag = 8'h50;
            3'h6: large_mag = 8'h6a;
            default: large_mag = 8'hb7;
        endcase
    endfunction

    function automatic logic [7:0] apply_mod(input logic [7:0] c, input logic [7:0] m, input logic neg);
        logic [8:0] sum;
        sum = 9'h000;
        if (neg)
        begin
            sum = {1'b0, c} - {1'b0, m};
            apply_mod = sum[8] ? 8'h00 : sum[7:0]; // see RL23
        end
        else
        begin
            sum = {1'b0, c} + {1'b0, m};
            apply_mod = sum[8] ? 8'hff : sum[7:0]; // see RL23
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // stage 0 decode, combinational on the request word
    logic [63:0] w;
    logic [5:0] red_sum;
    logic [5:0] green_sum;
    logic [5:0] blue_sum;
    logic [2:0] red_delta;
    logic [2:0] green_delta;
    logic [2:0] blue_delta;
    logic split_orientation_bit;
    logic second_sub;
    logic [3:0] pix;
    logic [1:0] pix_index;
    rbmd_mode_t mode;
    logic [23:0] base;
    logic [2:0] sel;

    assign w = req.word; // see RL1
    assign red_delta = w[58:56];
    assign green_delta = w[50:48];
    assign blue_delta = w[42:40];
    // 6-bit signed sums: bit 5 set or above 31 flags overflow
    assign red_sum = {1'b0, w[63:59]} + {{3{red_delta[2]}}, red_delta}; // see RL3
    assign green_sum = {1'b0, w[55:51]} + {{3{green_delta[2]}}, green_delta}; // see RL3
    assign blue_sum = {1'b0, w[47:43]} + {{3{blue_delta[2]}}, blue_delta}; // see RL3
    assign split_orientation_bit = w[`RBMD_ORIENT_BIT]; // see RL8
    // pixel number in column order: a=0, b=1, ... p=15
    assign pix = {req.col, req.row}; // see RL1
    assign second_sub = split_orientation_bit ? req.row[1] : req.col[1]; // see RL9 see RL10
    assign pix_index = {w[`RBMD_IDX_MSB_LO + 32'(pix)], w[`RBMD_IDX_LSB_LO + 32'(pix)]}; // see RL18

    always_comb
    begin
        if (!w[`RBMD_DIFF_BIT])
        begin
            mode = RBMD_INDIVIDUAL; // see RL2
        end
        else if (red_sum[5])
        begin
            mode = RBMD_T_MODE; // see RL4
        end
        else if (green_sum[5])
        begin
            mode = RBMD_H_MODE; // see RL5
        end
        else if (blue_sum[5])
        begin
            mode = RBMD_PLANAR; // see RL6
        end
        else
        begin
            mode = RBMD_DIFFERENTIAL; // see RL7
        end
    end

    always_comb
    begin
        sel = second_sub ? w[`RBMD_SEL2_LO +: 3] : w[`RBMD_SEL1_LO +: 3]; // see RL15
        case (mode)
            RBMD_INDIVIDUAL: // see RL14
            begin
                if (second_sub)
                begin
                    base = {nibble_widen(w[59:56]), nibble_widen(w[51:48]), nibble_widen(w[43:40])}; // see RL12
                end
                else
                begin
                    base = {nibble_widen(w[63:60]), nibble_widen(w[55:52]), nibble_widen(w[47:44])}; // see RL11
                end
            end
            RBMD_DIFFERENTIAL:
            begin
                if (second_sub)
                begin
                    base = {quint_widen(red_sum[4:0]), quint_widen(green_sum[4:0]),
                        quint_widen(blue_sum[4:0])}; // see RL17
                end
                else
                begin
                    base = {quint_widen(w[63:59]), quint_widen(w[55:51]), quint_widen(w[47:43])}; // see RL16
                end
            end
            RBMD_T_MODE:
            begin
                // first colour only, paint colours are not constructed by any stage
                base = {nibble_widen({w[60:59], w[57:56]}), nibble_widen(w[55:52]),
                    nibble_widen(w[51:48])}; // see RL19
            end
            RBMD_PLANAR:
            begin
                // origin colour only: red 6 bits widened by top-two replication
                base = {w[62:57], w[62:61], quint_widen(5'(w[56:53])), 8'h00}; // see RL20
            end
            default:
            begin
                base = {nibble_widen(w[62:59]), nibble_widen({w[58:56], w[52]}), 8'h00};
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_d = st_q;
        if (advance && !st_q.out_valid)
        begin
            // stage 1: capture mode, base colour and modifier
            st_d.s1_valid = req_valid; // see RL24
            st_d.s1_mode = mode;
            st_d.s1_base = base;
            st_d.s1_pix = pix;
            st_d.s1_mod = pix_index[0] ? large_mag(sel) : small_mag(sel); // see RL22
            st_d.s1_neg = pix_index[1]; // see RL22
            // stage 2: apply modifier on the modifier modes
            st_d.s2_valid = st_q.s1_valid;
            st_d.s2_resp.mode = st_q.s1_mode;
            if (st_q.s1_mode == RBMD_INDIVIDUAL || st_q.s1_mode == RBMD_DIFFERENTIAL)
            begin
                st_d.s2_resp.red = apply_mod(st_q.s1_base[23:16], st_q.s1_mod, st_q.s1_neg); // see RL23
                st_d.s2_resp.green = apply_mod(st_q.s1_base[15:8], st_q.s1_mod, st_q.s1_neg);
                st_d.s2_resp.blue = apply_mod(st_q.s1_base[7:0], st_q.s1_mod, st_q.s1_neg);
            end
            else
            begin
                st_d.s2_resp.red = st_q.s1_base[23:16];
                st_d.s2_resp.green = st_q.s1_base[15:8];
                st_d.s2_resp.blue = st_q.s1_base[7:0];
            end
        end
        // output register drained from fifo
        // an empty fifo shows stale or unwritten memory, so the answer word loads only with valid data
        if (!st_q.out_valid || resp_ready)
        begin
            st_d.out_valid = fifo_out_valid;
            if (fifo_out_valid)
            begin
                st_d.out_resp = fifo_out_data;
            end
        end
        // the stages stall while the output register is full, so the fifo holds one word at most
        // and a ready registered from its present room cannot overrun it
        st_d.ready = !st_d.out_valid && fifo_in_ready;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_q <= '0;
            // requests are welcome from the first edge after release
            st_q.ready <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    rbmd_fifo #(
        .WIDTH($bits(rbmd_resp_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(st_q.s2_valid && advance && !st_q.out_valid),
        .in_ready(fifo_in_ready),
        .in_data(st_q.s2_resp),
        .out_valid(fifo_out_valid),
        .out_ready(!st_q.out_valid || resp_ready),
        .out_data(fifo_out_data)
    );

    assign resp_valid = st_q.out_valid;
    assign resp = st_q.out_resp;
endmodule

/* tb/rbmd_decoder_chk.sv */
// port-level checks of the block mode decoder handshake and answer timing
// assumes binding to rbmd_decoder, one clock, synchronous active-high reset
`timescale 1ns/1ps
module rbmd_decoder_chk #(
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // request side
    input wire logic req_valid,
    input wire logic req_ready,
    // answer side
    input wire logic resp_valid,
    input wire logic resp_ready,
    input wire rbmd_pkg::rbmd_resp_t resp
);
    import rbmd_pkg::*;
    logic [7:0] pend_q;
    logic [7:0] pend_d;
    logic take;
    logic give;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////////
    // answers owed: taken requests minus delivered answers
    assign take = req_valid && req_ready;
    assign give = resp_valid && resp_ready;
    always_comb pend_d = pend_q + 8'(take) - 8'(give);
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            pend_q <= 8'h00;
        else
            pend_q <= pend_d;
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_rst_idle: assert property ($fell(sys_rst) |-> !resp_valid && resp == '0)
        else $error("answer not idle after reset");
    a_ready_after_rst: assert property ($fell(sys_rst) |-> req_ready)
        else $error("request refused after reset");
    a_hold_valid: assert property (resp_valid && !resp_ready |=> resp_valid)
        else $error("answer withdrawn before taken");
    a_hold_data: assert property (resp_valid && !resp_ready |=> $stable(resp))
        else $error("answer changed before taken");
    a_refuse_busy: assert property (resp_valid && !resp_ready |-> !req_ready)
        else $error("request accepted while answer waits");
    a_mode_range: assert property (resp_valid |-> resp.mode <= RBMD_PLANAR)
        else $error("answer mode code out of range");
    a_answer_due: assert property (take |-> ##[3:300] resp_valid)
        else $error("no answer after request");
    a_no_phantom: assert property (resp_valid |-> pend_q != 8'h00)
        else $error("answer without request");
    a_min_latency: assert property (take && pend_q == 8'h00 |=> !resp_valid [*2])
        else $error("answer too early");
    a_backlog_cap: assert property (pend_q <= 8'(FIFO_DEPTH + 4))
        else $error("more requests taken than buffered");
    c_stall: cover property (resp_valid && !resp_ready ##1 resp_valid && resp_ready);
    c_refuse: cover property (req_valid && !req_ready);
    c_t_mode: cover property (give && resp.mode == RBMD_T_MODE);
endmodule

/* tb/rbmd_sampler_model.sv */
// downstream sampler model: takes answers at full rate, one cycle in four, or never
// assumes the decoder's clock and synchronous active-high reset
`timescale 1ns/1ps
module rbmd_sampler_model (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // pace: 0 always ready, 1 every fourth cycle, 2 stalled
    input wire logic [1:0] pace,
    // answer handshake
    output logic resp_ready
);
    logic [1:0] tick_q;
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            tick_q <= 2'h0;
        else
            tick_q <= tick_q + 2'h1;
    end
    // ready may drop while an answer waits; the decoder has to hold it
    assign resp_ready = !sys_rst && (pace == 2'h0 || (pace == 2'h1 && tick_q == 2'h3));
endmodule

/* tb/test_rgb_block_mode_decoder.sv */
// testbench of the block mode decoder: request tasks, reference decode, answer scoreboard
// assumes rbmd_pkg compiled first and the checker bound to the decoder
`timescale 1ns/1ps
module test_rgb_block_mode_decoder;
    import rbmd_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_ready;
    rbmd_req_t req = '0;
    logic resp_valid;
    logic resp_ready;
    rbmd_resp_t resp;
    rbmd_resp_t e_got;
    logic [1:0] pace = 2'h0;
    rbmd_resp_t exp_q[$];
    int errors = 0;
    int compares = 0;
    logic [31:0] his[9] = '{32'he33c81e8, 32'he33c81e9, 32'he422181e, 32'hf803f8af, 32'hf9000002,
        32'h04000002, 32'h00f90002, 32'h5a000702, 32'hf9f9f9fc};
    always #20 clk = ~clk;
    rbmd_decoder #(.FIFO_DEPTH(16)) rbmd_decoder_inst (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .resp_valid(resp_valid), .resp_ready(resp_ready), .resp(resp));
    rbmd_sampler_model rbmd_sampler_model_inst (.clk(clk), .sys_rst(sys_rst), .pace(pace),
        .resp_ready(resp_ready));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic rbmd_resp_t exp_of(input logic [63:0] w, input logic [1:0] c, input logic [1:0] r);
        rbmd_resp_t e;
        int sm[8] = '{2, 5, 9, 13, 18, 24, 33, 47};
        int lg[8] = '{8, 17, 29, 42, 60, 80, 106, 183};
        int s[3];
        int b[3];
        int f;
        int p;
        int mv;
        logic sub2;
        logic [2:0] sel;
        p = c * 4 + r;
        sub2 = w[32] ? r[1] : c[1];
        sel = sub2 ? w[36:34] : w[39:37];
        case ({w[16 + p], w[p]})
            2'b11: mv = -lg[sel];
            2'b10: mv = -sm[sel];
            2'b00: mv = sm[sel];
            default: mv = lg[sel];
        endcase
        for (int i = 0; i < 3; i++)
        begin
            f = w[63 - 8 * i -: 5];
            s[i] = f + $signed(w[58 - 8 * i -: 3]);
            if (!w[33])
                b[i] = 17 * (sub2 ? w[59 - 8 * i -: 4] : w[63 - 8 * i -: 4]);
            else
            begin
                f = sub2 ? s[i] : f;
                b[i] = f * 8 + f / 4;
            end
            b[i] = b[i] + mv;
            b[i] = b[i] < 0 ? 0 : (b[i] > 255 ? 255 : b[i]);
        end
        e.red = 8'(b[0]);
        e.green = 8'(b[1]);
        e.blue = 8'(b[2]);
        if (!w[33])
            e.mode = RBMD_INDIVIDUAL;
        else if (s[0] < 0 || s[0] > 31)
            e.mode = RBMD_T_MODE;
        else if (s[1] < 0 || s[1] > 31)
            e.mode = RBMD_H_MODE;
        else if (s[2] < 0 || s[2] > 31)
            e.mode = RBMD_PLANAR;
        else
            e.mode = RBMD_DIFFERENTIAL;
        // t mode shows its first base colour, planar only its widened origin red
        if (e.mode == RBMD_T_MODE)
        begin
            e.red = 8'(17 * {w[60:59], w[57:56]});
            e.green = 8'(17 * w[55:52]);
            e.blue = 8'(17 * w[51:48]);
        end
        if (e.mode == RBMD_PLANAR)
            e.red = {w[62:57], w[62:61]};
        return e;
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // entered at a rising edge; leaves valid high so requests run back to back
    task automatic send(input logic [63:0] w, input logic [1:0] c, input logic [1:0] r, input int lim,
        output logic ok);
        req <= '{w, c, r};
        req_valid <= 1'b1;
        ok = 1'b0;
        for (int n = 0; n < lim && !ok; n++)
        begin
            @(negedge clk);
            ok = req_ready === 1'b1;
        end
        if (ok)
        begin
            @(posedge clk);
            exp_q.push_back(exp_of(w, c, r));
        end
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        if (!sys_rst && resp_valid === 1'b1 && resp_ready === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(1, 0, "extra answer");
            else
            begin
                e_got = exp_q.pop_front();
                if (e_got.mode == RBMD_INDIVIDUAL || e_got.mode == RBMD_DIFFERENTIAL)
                    check(resp, e_got, "colour");
                else if (e_got.mode == RBMD_T_MODE)
                    check(resp, e_got, "t colour");
                else if (e_got.mode == RBMD_PLANAR)
                    check({resp.red, resp.mode}, {e_got.red, e_got.mode}, "planar origin");
                else
                    check(resp.mode, e_got.mode, "mode");
            end
        end
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
    initial
    begin
        logic [31:0] hi;
        logic [3:0] j;
        logic ok;
        int n;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        // fixed mode words, then every modifier selector in both orientations, all 16 pixels each
        for (int k = 0; k < 25; k++)
        begin
            j = 4'(k - 9);
            hi = k < 9 ? his[k] : {24'h808080, j[3:1], j[3:1], 1'b1, j[0]};
            pace <= k < 9 ? 2'h0 : 2'h1;
            for (int p = 0; p < 16; p++)
            begin
                send({hi, 32'h5a3c0ff0}, 2'(p / 4), 2'(p % 4), 500, ok);
                check(ok, 1, "request taken");
            end
        end
        req_valid <= 1'b0;
        pace <= 2'h2;
        @(posedge clk);
        // fill the buffer against a stalled sampler until refused
        for (n = 0; n < 40; n++)
        begin
            send({his[2], 32'h0000ffff}, 2'h3, 2'h3, 3, ok);
            if (!ok)
                break;
        end
        repeat (5) @(negedge clk);
        check(req_ready, 0, "ready while full");
        @(posedge clk);
        req_valid <= 1'b0;
        pace <= 2'h1;
        for (n = 0; n < 2000 && exp_q.size() != 0; n++)
            @(posedge clk);
        @(negedge clk);
        check(exp_q.size(), 0, "answers missing");
        check(resp_valid, 0, "valid after drain");
        tally_and_finish();
    end
endmodule
bind rbmd_decoder rbmd_decoder_chk #(.FIFO_DEPTH(FIFO_DEPTH)) rbmd_decoder_chk_inst (.clk(clk), .sys_rst(sys_rst),
    .req_valid(req_valid), .req_ready(req_ready), .resp_valid(resp_valid), .resp_ready(resp_ready), .resp(resp));
